// File: ufr_fuse_row.sv
// Notes on behaviour
// - Nineteen fuses, one byte address each
// - Program like code; chip erase spares fuses
// - Writing 00H clears a fuse anytime; here only in an allowed session with lock mode below two
// - Setting to FFH needs whole-row erase
// - Primary clock source pair decode
// - Start-up pair selects wake-up delay
// - Byte 06H selects twelve-clock or single-cycle
// - Byte 07H enables serial programming
// - Byte 08H halves system clock when FFh
// - Byte 05H sets expanded RAM reset value
// - Tristate fuse selects port reset mode
// - Low-power pair decode
// - Secondary clock source pair decode
// - Factory values FFh except three at 00H
// - Clock source changes wait for power-on
// - Programming enable updates at session end
// - Lock mode two or more refuses programming
//
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none

module ufr_fuse_row (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [ufr_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic por_pin_n,
  input wire logic session_pin,
  input wire logic [2:0] lock_mode,
  output ufr_pkg::ufr_cfg_s cfg,
  output logic prog_enable,
  output logic session_open
);

  logic [ufr_pkg::ROW_W-1:0] row_q, row_d;
  logic [ufr_pkg::ROW_W-1:0] stage_q, stage_d;
  ufr_pkg::ufr_cfg_s cfg_q;
  logic prog_en_q;
  logic por_entry_q;
  logic refused_q;
  logic [31:0] prdata_q;
  logic por_s1_q, por_s2_q, ses_s1_q, ses_s2_q, ses_prev_q;

  // Pins from the programmer are asynchronous
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      por_s1_q <= 1'b0;
      por_s2_q <= 1'b0;
      ses_s1_q <= 1'b0;
      ses_s2_q <= 1'b0;
      ses_prev_q <= 1'b0;
    end else begin
      por_s1_q <= por_pin_n;
      por_s2_q <= por_s1_q;
      ses_s1_q <= session_pin;
      ses_s2_q <= ses_s1_q;
      ses_prev_q <= ses_s2_q;
    end
  end

  wire por_active = ~por_s2_q;
  wire session_act = ses_s2_q;
  wire session_end = ses_prev_q & ~ses_s2_q;

  // Decode
  wire acc = psel & penable;
  wire wr = acc & pwrite;
  // Word index within a page; the page itself comes from paddr[11:8]
  wire [5:0] widx = paddr[7:2];
  wire word_ok = paddr[1:0] == 2'b00 && widx < 6'(ufr_pkg::FUSE_COUNT);
  wire in_fuse = word_ok && paddr[11:8] == ufr_pkg::PAGE_FUSE;
  wire in_stage = word_ok && paddr[11:8] == ufr_pkg::PAGE_STAGE;
  wire is_cmd = paddr == ufr_pkg::ADDR_CMD;
  wire is_stat = paddr == ufr_pkg::ADDR_STATUS;
  wire is_cfg = paddr == ufr_pkg::ADDR_CFG;
  wire mapped = in_fuse | in_stage | is_cmd | is_stat | is_cfg;
  wire [4:0] bidx = widx[4:0];

  wire session_allowed = prog_en_q | por_entry_q;
  wire lock_ok = lock_mode < ufr_pkg::LOCK_BLOCK_MODE;
  wire prog_ok = session_act & session_allowed & lock_ok;

  wire cmd_wr = wr & is_cmd;
  wire [1:0] cmd_op = pwdata[1:0];
  wire wants_prog = (wr & in_fuse) | (cmd_wr &
    (cmd_op == ufr_pkg::CMD_ERASE_ROW || cmd_op == ufr_pkg::CMD_WRITE_AUTO));
  wire refuse = wants_prog & ~prog_ok;
  wire fuse_wr_go = wr & in_fuse & prog_ok;
  wire erase_go = cmd_wr & cmd_op == ufr_pkg::CMD_ERASE_ROW & prog_ok;
  wire auto_go = cmd_wr & cmd_op == ufr_pkg::CMD_WRITE_AUTO & prog_ok;
  // Chip erase belongs to the other arrays; the fuse row ignores it
  wire chip_go = cmd_wr & cmd_op == ufr_pkg::CMD_CHIP_ERASE;

  assign pready = 1'b1;
  assign pslverr = acc & (~mapped | refuse);

  genvar gi;
  generate
    for (gi = 0; gi < ufr_pkg::FUSE_COUNT; gi++) begin : g_byte
      wire hit = bidx == 5'(gi);
      // Programming only pulls bits low; only a row erase or an auto write from staging raises them
      assign row_d[gi*8 +: 8] =
        erase_go ? ufr_pkg::FUSE_ERASED :
        auto_go ? stage_q[gi*8 +: 8] :
        (fuse_wr_go & hit) ? row_q[gi*8 +: 8] & pwdata[7:0] :
        row_q[gi*8 +: 8];
      assign stage_d[gi*8 +: 8] = (wr & in_stage & hit) ? pwdata[7:0]
        : stage_q[gi*8 +: 8];
    end
  endgenerate

  wire [7:0] rd_fuse = row_q[bidx*8 +: 8];
  wire [7:0] rd_stage = stage_q[bidx*8 +: 8];
  wire [31:0] status_w = {27'h0, lock_ok, refused_q, session_allowed,
    prog_en_q, session_act};
  wire [31:0] rd_mux =
    in_fuse ? {24'h0, rd_fuse} :
    in_stage ? {24'h0, rd_stage} :
    is_stat ? status_w :
    is_cfg ? {1'b0, cfg_q} : 32'h0;

  // Row and staging model the nonvolatile cells; reset stands for delivery
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      row_q <= ufr_pkg::FACTORY_ROW;
      stage_q <= ufr_pkg::FACTORY_ROW;
    end else begin
      row_q <= row_d;
      stage_q <= stage_d;
    end
  end

  // Read data sampled in the setup phase, so no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0;
      refused_q <= 1'b0;
    end else begin
      if (psel & ~penable & ~pwrite) begin
        prdata_q <= rd_mux;
      end
      if (acc & wants_prog) begin
        refused_q <= refuse;
      end
    end
  end

  // Config follows the row while power-on is held, then stays frozen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= ufr_pkg::CFG_FACTORY;
      prog_en_q <= 1'b1;
      por_entry_q <= 1'b0;
    end else begin
      if (por_active) begin
        cfg_q <= ufr_pkg::ufr_decode(row_q);
      end
      if (por_active | session_end) begin
        prog_en_q <= &row_q[ufr_pkg::IDX_PROG_EN*8 +: 8];
      end
      // A session opened during power-on stays allowed until it ends
      if (por_active & session_act) begin
        por_entry_q <= 1'b1;
      end else if (~session_act) begin
        por_entry_q <= 1'b0;
      end
    end
  end

  assign prdata = prdata_q;
  assign cfg = cfg_q;
  assign prog_enable = prog_en_q;
  assign session_open = session_act & session_allowed;

  logic [4:0] chk_idx_q;
  logic [7:0] chk_exp_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chk_idx_q <= 5'h0;
      chk_exp_q <= 8'h0;
    end else begin
      chk_idx_q <= bidx;
      chk_exp_q <= rd_fuse & pwdata[7:0];
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  fuse_clear_only_a: assert property (
    fuse_wr_go |=> row_q[chk_idx_q*8 +: 8] == chk_exp_q)
    else $error("fuse write did not AND into the byte");

  row_erase_a: assert property (
    erase_go |=> row_q == {ufr_pkg::ROW_W{1'b1}})
    else $error("row erase left a cleared byte");

  chip_erase_keep_a: assert property (
    chip_go |=> $stable(row_q))
    else $error("chip erase changed the fuse row");

  lock_refuse_a: assert property (
    wr & in_fuse & ~lock_ok |-> pslverr ##1 $stable(row_q))
    else $error("locked fuse write was not refused");

  cfg_hold_a: assert property (
    ~por_active & $past(~por_active) |-> $stable(cfg_q))
    else $error("config changed outside power-on");

  prog_en_time_a: assert property (
    $changed(prog_en_q) |-> $past(por_active | session_end))
    else $error("programming enable moved outside its events");

  cfg_capture_a: assert property (
    por_active |=> cfg_q == ufr_pkg::ufr_decode($past(row_q)))
    else $error("config not captured from row during power-on");

  halve_decode_a: assert property (
    por_active |=> cfg_q.halved_clock_setting ==
      $past(&row_q[ufr_pkg::IDX_HALVE*8 +: 8]))
    else $error("clock halving decode wrong");

  compat_decode_a: assert property (
    por_active |=> cfg_q.compat_timing ==
      $past(&row_q[ufr_pkg::IDX_COMPAT*8 +: 8]))
    else $error("timing mode decode wrong");

  auto_write_a: assert property (
    auto_go |=> row_q == $past(stage_q))
    else $error("auto-erase write did not copy staging");

  cover_fuse_write_c: cover property (fuse_wr_go);
  cover_auto_write_c: cover property (auto_go ##[1:20] session_end);
  cover_locked_c: cover property (refuse);

endmodule : ufr_fuse_row

`default_nettype wire

// File: ufr_pkg.sv
package ufr_pkg;

  localparam int FUSE_COUNT = 19;
  localparam int ROW_W = FUSE_COUNT * 8;
  localparam logic [7:0] FUSE_ERASED = 8'hFF;

  // Byte index of each fuse in the row; pairs are low then high fuse
  localparam int IDX_PRI_LO = 'h00;
  localparam int IDX_PRI_HI = 'h01;
  localparam int IDX_WAKE_LO = 'h02;
  localparam int IDX_WAKE_HI = 'h03;
  localparam int IDX_BOOT = 'h04;
  localparam int IDX_XRAM = 'h05;
  localparam int IDX_COMPAT = 'h06;
  localparam int IDX_PROG_EN = 'h07;
  localparam int IDX_HALVE = 'h08;
  localparam int IDX_TRISTATE = 'h0B;
  localparam int IDX_PWR_LO = 'h0D;
  localparam int IDX_PWR_HI = 'h0E;
  localparam int IDX_SEC_LO = 'h11;
  localparam int IDX_SEC_HI = 'h12;

  // Factory row: all erased except tristate, boot jump and expanded RAM
  localparam logic [ROW_W-1:0] FACTORY_ROW = {{7{8'hFF}}, 8'h00,
    {5{8'hFF}}, {2{8'h00}}, {4{8'hFF}}};

  // APB map, byte addresses
  localparam int ADDR_W = 12;
  localparam logic [3:0] PAGE_FUSE = 4'h0;
  localparam logic [3:0] PAGE_STAGE = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_CMD = 12'h200;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h204;
  localparam logic [ADDR_W-1:0] ADDR_CFG = 12'h208;

  localparam logic [1:0] CMD_ERASE_ROW = 2'h1;
  localparam logic [1:0] CMD_CHIP_ERASE = 2'h2;
  localparam logic [1:0] CMD_WRITE_AUTO = 2'h3;

  localparam logic [2:0] LOCK_BLOCK_MODE = 3'h2;

  // Clock rate and start-up delays
  localparam int CLK_HZ = 10_000_000;
  localparam int CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int WAKE_XTAL_US [4] = '{1000, 2000, 4000, 16000};
  localparam int WAKE_FAST_US [4] = '{16, 512, 1000, 4000};

  typedef enum logic [1:0] {
    UFR_SRC_XTAL_HS = 2'h0,
    UFR_SRC_XTAL_LOW = 2'h1,
    UFR_SRC_EXT = 2'h2,
    UFR_SRC_RC = 2'h3
  } ufr_clk_src_e;

  typedef enum logic [1:0] {
    UFR_PWR_NORMAL = 2'h0,
    UFR_PWR_LOW = 2'h1,
    UFR_PWR_EXTRA_LOW = 2'h2
  } ufr_power_e;

  typedef struct packed {
    ufr_clk_src_e primary_clock_source_sel;
    ufr_clk_src_e secondary_clock_source_sel;
    logic [1:0] startup_timeout_sel;
    logic [17:0] startup_cycles;
    logic boot_jump;
    logic expanded_ram_select_bit;
    logic compat_timing;
    logic halved_clock_setting;
    logic ports_tristate;
    ufr_power_e power_level_sel;
  } ufr_cfg_s;

  function automatic ufr_cfg_s ufr_decode(input logic [ROW_W-1:0] row);
    ufr_cfg_s c;
    logic [FUSE_COUNT-1:0] u;
    logic xtal;
    int us;
    for (int i = 0; i < FUSE_COUNT; i++) begin
      u[i] = &row[i*8 +: 8];
    end
    case ({u[IDX_PRI_HI], u[IDX_PRI_LO]})
      2'b11: c.primary_clock_source_sel = UFR_SRC_XTAL_HS;
      2'b10: c.primary_clock_source_sel = UFR_SRC_XTAL_LOW;
      2'b01: c.primary_clock_source_sel = UFR_SRC_EXT;
      default: c.primary_clock_source_sel = UFR_SRC_RC;
    endcase
    case ({u[IDX_SEC_HI], u[IDX_SEC_LO]})
      2'b11, 2'b10: c.secondary_clock_source_sel = UFR_SRC_XTAL_LOW;
      2'b01: c.secondary_clock_source_sel = UFR_SRC_EXT;
      default: c.secondary_clock_source_sel = UFR_SRC_RC;
    endcase
    c.startup_timeout_sel = {u[IDX_WAKE_HI], u[IDX_WAKE_LO]};
    xtal = c.primary_clock_source_sel == UFR_SRC_XTAL_HS ||
      c.primary_clock_source_sel == UFR_SRC_XTAL_LOW;
    us = xtal ? WAKE_XTAL_US[c.startup_timeout_sel]
      : WAKE_FAST_US[c.startup_timeout_sel];
    c.startup_cycles = 18'(us * CYC_PER_US);
    c.boot_jump = u[IDX_BOOT];
    c.expanded_ram_select_bit = u[IDX_XRAM];
    c.compat_timing = u[IDX_COMPAT];
    c.halved_clock_setting = u[IDX_HALVE];
    c.ports_tristate = u[IDX_TRISTATE];
    case ({u[IDX_PWR_HI], u[IDX_PWR_LO]})
      2'b11: c.power_level_sel = UFR_PWR_LOW;
      2'b01: c.power_level_sel = UFR_PWR_EXTRA_LOW;
      default: c.power_level_sel = UFR_PWR_NORMAL;
    endcase
    return c;
  endfunction : ufr_decode

  localparam ufr_cfg_s CFG_FACTORY = ufr_decode(FACTORY_ROW);

endpackage : ufr_pkg

// File: ufr_prog_model.sv
`timescale 1ns/1ps
`default_nettype none

module ufr_prog_model (
  input wire logic pclk,
  output var logic [ufr_pkg::ADDR_W-1:0] paddr,
  output var logic psel,
  output var logic penable,
  output var logic pwrite,
  output var logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output var logic session_pin
);
  logic [7:0] shadow [ufr_pkg::FUSE_COUNT];

  initial begin
    paddr = '0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = '0;
    session_pin = 1'b0;
  end

  // Request held until pready is sampled high; only the bench timeout
  // ends a wait that never completes
  task automatic xfer(input logic wr, input logic [ufr_pkg::ADDR_W-1:0] a,
      input logic [31:0] d, output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  // Driving the pin low ends the session
  task automatic session(input logic on);
    session_pin <= on;
    repeat (6) @(posedge pclk);
  endtask : session

  task automatic fetch();
    logic [31:0] rd;
    logic e;
    for (int i = 0; i < ufr_pkg::FUSE_COUNT; i++) begin
      xfer(1'b0, 12'(4 * i), 32'h0, rd, e);
      shadow[i] = rd[7:0];
    end
  endtask : fetch

  task automatic commit(output logic err);
    logic [31:0] rd;
    logic e;
    for (int i = 0; i < ufr_pkg::FUSE_COUNT; i++) begin
      xfer(1'b1, 12'(12'h100 + 4 * i), {24'h0, shadow[i]}, rd, e);
    end
    xfer(1'b1, ufr_pkg::ADDR_CMD, {30'h0, ufr_pkg::CMD_WRITE_AUTO}, rd, err);
  endtask : commit
endmodule : ufr_prog_model

`default_nettype wire

// File: testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic pclk;
  logic presetn;
  logic por_pin_n;
  logic [2:0] lock_mode;
  logic [ufr_pkg::ADDR_W-1:0] paddr;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic session_pin;
  logic prog_enable;
  logic session_open;
  ufr_pkg::ufr_cfg_s cfg;
  int mismatches;
  int compares;
  int cycles;
  logic [31:0] rd;
  logic err;

  ufr_fuse_row u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .por_pin_n(por_pin_n), .session_pin(session_pin),
    .lock_mode(lock_mode), .cfg(cfg), .prog_enable(prog_enable),
    .session_open(session_open));

  ufr_prog_model u_prog (.pclk(pclk), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .session_pin(session_pin));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic end_of_test;
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      end_of_test();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s exp %0h got %0h", what, exp, got);
    end
  endtask : chk

  task automatic rf(input int i);
    u_prog.xfer(1'b0, 12'(4 * i), 32'h0, rd, err);
  endtask : rf

  task automatic wf(input int i, input logic [7:0] v);
    u_prog.xfer(1'b1, 12'(4 * i), {24'h0, v}, rd, err);
  endtask : wf

  task automatic cmd(input logic [1:0] c);
    u_prog.xfer(1'b1, ufr_pkg::ADDR_CMD, {30'h0, c}, rd, err);
  endtask : cmd

  task automatic por_pulse;
    por_pin_n <= 1'b0;
    repeat (6) @(posedge pclk);
    por_pin_n <= 1'b1;
    repeat (6) @(posedge pclk);
  endtask : por_pulse

  task automatic t_defaults;
    for (int i = 0; i < 19; i++) begin
      rf(i);
      chk("fuse", (i == 4 || i == 5 || i == 11) ? 32'h0 : 32'hFF, rd);
    end
    rf(19);
    chk("past end", 32'h1, err);
    u_prog.xfer(1'b0, 12'h300, 32'h0, rd, err);
    chk("unmapped", 32'h1, err);
    chk("ready", 32'h1, pready);
    chk("prog_en", 32'h1, prog_enable);
  endtask : t_defaults

  task automatic t_decode;
    int us [4] = '{16, 512, 4000, 16000};
    logic [1:0] pri [4] = '{2'h3, 2'h2, 2'h1, 2'h0};
    logic [1:0] sec [4] = '{2'h3, 2'h2, 2'h1, 2'h1};
    logic [1:0] pw [4] = '{2'h0, 2'h2, 2'h0, 2'h1};
    u_prog.session(1'b1);
    for (int k = 0; k < 4; k++) begin
      u_prog.fetch();
      for (int j = 0; j < 19; j++) begin
        if (j inside {0, 2, 4, 8, 11, 13, 17}) u_prog.shadow[j] = {8{k[0]}};
        if (j inside {1, 3, 5, 6, 14, 18}) u_prog.shadow[j] = {8{k[1]}};
      end
      u_prog.commit(err);
      chk("commit", 32'h0, err);
      por_pulse();
      chk("pri", pri[k], cfg.primary_clock_source_sel);
      chk("wake", k, cfg.startup_timeout_sel);
      chk("boot", k[0], cfg.boot_jump);
      chk("cyc", us[k] * 10, cfg.startup_cycles);
      chk("pwr", pw[k], cfg.power_level_sel);
      chk("sec", sec[k], cfg.secondary_clock_source_sel);
      chk("cpu", k[1], cfg.compat_timing);
      chk("half", k[0], cfg.halved_clock_setting);
      chk("xram", k[1], cfg.expanded_ram_select_bit);
      chk("tri", k[0], cfg.ports_tristate);
    end
  endtask : t_decode

  task automatic t_clear;
    wf(0, 8'h00);
    rf(0);
    chk("clear", 32'h0, rd);
    wf(0, 8'hFF);
    rf(0);
    chk("no set", 32'h0, rd);
    cmd(ufr_pkg::CMD_CHIP_ERASE);
    rf(0);
    chk("chip erase", 32'h0, rd);
    wf(6, 8'h00);
    chk("pri held", 32'h0, cfg.primary_clock_source_sel);
    chk("cpu held", 32'h1, cfg.compat_timing);
    por_pulse();
    chk("pri new", 32'h1, cfg.primary_clock_source_sel);
    chk("cpu new", 32'h0, cfg.compat_timing);
    cmd(ufr_pkg::CMD_ERASE_ROW);
    rf(6);
    chk("row erase", 32'hFF, rd);
  endtask : t_clear

  task automatic t_lock;
    for (int m = 2; m < 5; m++) begin
      lock_mode <= 3'(m);
      wf(8, 8'h00);
      chk("locked", 32'h1, err);
      rf(8);
      chk("kept", 32'hFF, rd);
    end
    lock_mode <= 3'h1;
  endtask : t_lock

  task automatic t_prog_en;
    wf(7, 8'h00);
    chk("pe held", 32'h1, prog_enable);
    u_prog.session(1'b0);
    chk("pe new", 32'h0, prog_enable);
    u_prog.session(1'b1);
    wf(8, 8'h00);
    chk("no entry", 32'h1, err);
    u_prog.session(1'b0);
    por_pin_n <= 1'b0;
    u_prog.session(1'b1);
    por_pin_n <= 1'b1;
    repeat (6) @(posedge pclk);
    chk("open", 32'h1, session_open);
    wf(8, 8'h00);
    chk("por entry", 32'h0, err);
  endtask : t_prog_en

  initial begin
    presetn = 1'b0;
    por_pin_n = 1'b1;
    lock_mode = 3'h1;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    t_defaults();
    t_decode();
    t_clear();
    t_lock();
    t_prog_en();
    end_of_test();
  end
endmodule : testbench

`default_nettype wire
